/* File: rtl/prc_pkg.sv */
// clock ratio control package: register map, fields, codes and types
// Function
// - ratio register is 16-bit, word access only
// - power-on reset loads 0x0102, others keep it
// - multiplier field bits 15,5,4 selects ratio
// - core divider field bits 14,3,2
// - peripheral divider field bits 13,1,0
// - bits 12-9,7,6 read zero, read-only
// - bit 8 reads one, read-only
// - multiplier change halts cpu, gates clocks in modes 0-2 and 7, counts
// - counter overflow applies clocks, resumes, stops counting unless bit 7 is set
// - divider-only change never starts the counter
// - divider-only change outside settling applies ratios at once
// - 8-bit up-counter, overflow raises reset or interrupt
// - counter written only with key 0x5a
// - control byte written only with key 0xa5
// - counter and control cleared only by power-on
// - control byte survives overflow reset and settling
// - bit 7 enables counting, else count holds outside settling
// - control byte field layout, bit 7 down
// - bit 6 selects watchdog or interval mode
// - count clock divides peripheral clock by table
// - bit 5 picks power-on or manual reset
// - bit 4 watchdog flag, bit 3 interval flag
package prc_pkg;
    localparam logic [31:0] PRC_CNT_IDX   = 32'hffffff84;
    localparam logic [31:0] PRC_CSR_IDX   = 32'hffffff86;
    localparam logic [31:0] PRC_FRQ_IDX   = 32'hffffff80;
    localparam logic [31:0] PRC_STS_IDX   = 32'hffffff88;
    localparam logic [15:0] PRC_FRQ_RST   = 16'h0102;
    localparam logic [15:0] PRC_FRQ_WMASK = 16'he03f;
    localparam logic [15:0] PRC_FRQ_ONES  = 16'h0100;
    localparam logic [7:0]  PRC_CNT_RST   = 8'h00;
    localparam logic [7:0]  PRC_CSR_RST   = 8'h00;
    localparam logic [7:0]  PRC_CNT_KEY   = 8'h5a;
    localparam logic [7:0]  PRC_CSR_KEY   = 8'ha5;
    localparam logic [7:0]  PRC_CNT_MAX   = 8'hff;
    localparam logic [3:0]  PRC_WORD_STRB = 4'h3;
    localparam logic [1:0]  PRC_OKAY      = 2'h0;
    localparam logic [1:0]  PRC_SLVERR    = 2'h2;
    localparam int          PRC_TME       = 7;
    localparam int          PRC_MODE      = 6;
    localparam int          PRC_OVERFLOW_RESET_TYPE      = 5;
    localparam int          PRC_WATCHDOG_OVERFLOW_FLAG      = 4;
    localparam int          PRC_INTERVAL_OVERFLOW_FLAG      = 3;
    localparam int          PRC_PRE_W     = 12;
    localparam logic [2:0]  PRC_MODE_SLOW = 3'h7;
    localparam logic [2:0]  PRC_MODE_LAST = 3'h2;

    typedef struct packed {
        logic [2:0] mult;
        logic [2:0] core_div;
        logic [2:0] periph_div;
    } prc_clk_sel_t;

    typedef enum logic {
        PRC_RUN    = 1'b0,
        PRC_SETTLE = 1'b1
    } prc_state_t;

    function automatic prc_clk_sel_t prc_fields(input logic [15:0] f);
        prc_fields.mult       = {f[15], f[5], f[4]};
        prc_fields.core_div   = {f[14], f[3], f[2]};
        prc_fields.periph_div = {f[13], f[1], f[0]};
    endfunction : prc_fields

    function automatic logic [PRC_PRE_W-1:0] prc_div_mask(input logic [2:0] cks);
        case (cks)
            3'h0:    prc_div_mask = 12'h000;
            3'h1:    prc_div_mask = 12'h003;
            3'h2:    prc_div_mask = 12'h00f;
            3'h3:    prc_div_mask = 12'h01f;
            3'h4:    prc_div_mask = 12'h03f;
            3'h5:    prc_div_mask = 12'h0ff;
            3'h6:    prc_div_mask = 12'h3ff;
            default: prc_div_mask = 12'hfff;
        endcase
    endfunction : prc_div_mask

    function automatic logic prc_hit(input logic [31:0] a, input logic [31:0] idx);
        prc_hit = (a[31:2] == idx[29:0]);
    endfunction : prc_hit

    function automatic logic prc_codes_ok(input prc_clk_sel_t s);
        logic m_ok;
        logic c_ok;
        logic p_ok;
        m_ok = (s.mult inside {3'h0, 3'h1, 3'h4, 3'h2, 3'h5});
        c_ok = (s.core_div inside {3'h0, 3'h1, 3'h4, 3'h2});
        p_ok = (s.periph_div inside {3'h0, 3'h1, 3'h4, 3'h2, 3'h5});
        prc_codes_ok = m_ok & c_ok & p_ok;
    endfunction : prc_codes_ok
endpackage : prc_pkg

/* File: rtl/prc_clock_ratio_ctrl.sv */
// clock ratio control with pll settling counter behind an axi4-lite slave
`timescale 1ns/100ps
module prc_clock_ratio_ctrl (
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic [31:0]   s_axi_awaddr,
    input  wire logic [2:0]    s_axi_awprot,
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    output logic [1:0]         s_axi_bresp,
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    input  wire logic [31:0]   s_axi_araddr,
    input  wire logic [2:0]    s_axi_arprot,
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    output logic [31:0]        s_axi_rdata,
    output logic [1:0]         s_axi_rresp,
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready,
    input  wire logic [2:0]    clock_mode_pin,
    input  wire logic          periph_tick,
    output prc_pkg::prc_clk_sel_t clk_sel,
    output logic               cpu_halt,
    output logic               core_clk_run,
    output logic               periph_clk_run,
    output logic               wdt_por_req,
    output logic               wdt_manual_req,
    output logic               interval_req
);
    import prc_pkg::*;

    // ************************************************
    // clock mode pin synchroniser
    // ************************************************
    logic [2:0]     mode_meta;
    logic [2:0]     mode_sync;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_meta <= 3'h0;
            mode_sync <= 3'h0;
        end else begin
            mode_meta <= clock_mode_pin;
            mode_sync <= mode_meta;
        end
    end

    // ************************************************
    // write channels
    // ************************************************
    logic           aw_full;
    logic           w_full;
    logic [31:0]    aw_addr;
    logic [31:0]    w_data;
    logic [3:0]     w_strb;
    logic           wr_go;

    assign s_axi_awready = !aw_full;
    assign s_axi_wready  = !w_full;
    assign wr_go         = aw_full && w_full && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full <= 1'b0;
            aw_addr <= 32'h0;
        end else if (s_axi_awvalid && !aw_full) begin
            aw_full <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_full <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full <= 1'b0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid && !w_full) begin
            w_full <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (wr_go) begin
            w_full <= 1'b0;
        end
    end

    // ************************************************
    // write decode
    // ************************************************
    logic           hit_cnt;
    logic           hit_csr;
    logic           hit_frq;
    logic           hit_sts;
    logic           word_wr;
    logic           cnt_wr;
    logic           csr_wr;
    logic           frq_wr;
    logic [15:0]    next_frq;

    assign hit_cnt = prc_hit(aw_addr, PRC_CNT_IDX);
    assign hit_csr = prc_hit(aw_addr, PRC_CSR_IDX);
    assign hit_frq = prc_hit(aw_addr, PRC_FRQ_IDX);
    assign hit_sts = prc_hit(aw_addr, PRC_STS_IDX);
    assign word_wr = wr_go && (w_strb == PRC_WORD_STRB);
    assign cnt_wr  = word_wr && hit_cnt && (w_data[15:8] == PRC_CNT_KEY);
    assign csr_wr  = word_wr && hit_csr && (w_data[15:8] == PRC_CSR_KEY);
    assign frq_wr  = word_wr && hit_frq;
    assign next_frq = w_data[15:0] & PRC_FRQ_WMASK;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= PRC_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            if (hit_cnt || hit_csr || hit_frq || hit_sts) begin
                s_axi_bresp <= PRC_OKAY;
            end else begin
                s_axi_bresp <= PRC_SLVERR;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ************************************************
    // ratio register and settling sequence
    // ************************************************
    logic [15:0]    frq;
    prc_state_t     state;
    prc_clk_sel_t   new_sel;
    prc_clk_sel_t   cur_sel;
    logic           mult_change;
    logic           settling;
    logic           cnt_ovf;
    logic           gate_mode;

    assign new_sel     = prc_fields(next_frq);
    assign cur_sel     = prc_fields(frq);
    assign mult_change = (new_sel.mult != cur_sel.mult);
    assign settling    = (state == PRC_SETTLE);
    assign gate_mode   = (mode_sync <= PRC_MODE_LAST) || (mode_sync == PRC_MODE_SLOW);

    // only aresetn is a power-on reset; manual reset and standby never reach here
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            frq <= PRC_FRQ_RST & PRC_FRQ_WMASK;
        end else if (frq_wr) begin
            frq <= next_frq;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= PRC_RUN;
        end else begin
            case (state)
                PRC_RUN: begin
                    if (frq_wr && mult_change) begin
                        state <= PRC_SETTLE;
                    end
                end
                PRC_SETTLE: begin
                    if (cnt_ovf) begin
                        state <= PRC_RUN;
                    end
                end
                default: begin
                    state <= PRC_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clk_sel <= prc_fields(PRC_FRQ_RST);
        end else if (settling && cnt_ovf) begin
            clk_sel <= cur_sel;
        end else if (frq_wr && !mult_change && !settling) begin
            clk_sel <= new_sel;
        end
    end

    // clocks stop only during settling in the gated modes
    assign cpu_halt       = settling;
    assign core_clk_run   = !(settling && gate_mode);
    assign periph_clk_run = !(settling && gate_mode);

    // ************************************************
    // settling / watchdog counter
    // ************************************************
    logic [7:0]             cnt;
    logic [7:0]             csr;
    logic [PRC_PRE_W-1:0]   pre;
    logic [PRC_PRE_W-1:0]   mask;
    logic                   count_on;
    logic                   cnt_tick;
    logic                   wd_ovf;
    logic                   iv_ovf;

    // the counter's peripheral tick keeps running while other clocks are gated
    assign mask     = prc_div_mask(csr[2:0]);
    assign count_on = csr[PRC_TME] || settling;
    assign cnt_tick = count_on && periph_tick && ((pre & mask) == mask);
    assign cnt_ovf  = cnt_tick && (cnt == PRC_CNT_MAX);
    assign wd_ovf   = cnt_ovf && !settling && csr[PRC_MODE];
    assign iv_ovf   = cnt_ovf && !settling && !csr[PRC_MODE];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pre <= '0;
        end else if (periph_tick) begin
            pre <= pre + 12'h001;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt <= PRC_CNT_RST;
        end else if (cnt_wr) begin
            cnt <= w_data[7:0];
        end else if (cnt_tick) begin
            cnt <= cnt + 8'h01;
        end
    end

    // overflow flags: a set in the same cycle as a software write wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            csr <= PRC_CSR_RST;
        end else begin
            if (csr_wr) begin
                csr <= w_data[7:0];
            end
            if (wd_ovf) begin
                csr[PRC_WATCHDOG_OVERFLOW_FLAG] <= 1'b1;
            end
            if (iv_ovf) begin
                csr[PRC_INTERVAL_OVERFLOW_FLAG] <= 1'b1;
            end
        end
    end

    // requested resets go elsewhere; this block keeps state through them
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wdt_por_req    <= 1'b0;
            wdt_manual_req <= 1'b0;
            interval_req   <= 1'b0;
        end else begin
            wdt_por_req    <= wd_ovf && !csr[PRC_OVERFLOW_RESET_TYPE];
            wdt_manual_req <= wd_ovf && csr[PRC_OVERFLOW_RESET_TYPE];
            interval_req   <= iv_ovf;
        end
    end

    // ************************************************
    // read channel
    // ************************************************
    logic [31:0]    rd_word;
    logic           rd_hit;
    logic [15:0]    frq_view;

    assign frq_view      = (frq & PRC_FRQ_WMASK) | PRC_FRQ_ONES;
    assign s_axi_arready = !s_axi_rvalid;

    always_comb begin
        rd_word = 32'h0;
        rd_hit  = 1'b1;
        if (prc_hit(s_axi_araddr, PRC_CNT_IDX)) begin
            rd_word = {24'h0, cnt};
        end else if (prc_hit(s_axi_araddr, PRC_CSR_IDX)) begin
            rd_word = {24'h0, csr};
        end else if (prc_hit(s_axi_araddr, PRC_FRQ_IDX)) begin
            rd_word = {16'h0, frq_view};
        end else if (prc_hit(s_axi_araddr, PRC_STS_IDX)) begin
            rd_word = {20'h0, ~prc_codes_ok(cur_sel), gate_mode, settling, clk_sel};
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= PRC_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_hit ? PRC_OKAY : PRC_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule : prc_clock_ratio_ctrl

/* File: verif/prc_clock_ratio_ctrl_monitor.sv */
// concurrent checks on the ports of the clock ratio control block
`timescale 1ns/100ps
module prc_clock_ratio_ctrl_monitor (
    input wire logic                  aclk,
    input wire logic                  aresetn,
    input wire logic                  s_axi_awvalid,
    input wire logic                  s_axi_awready,
    input wire logic                  s_axi_wvalid,
    input wire logic                  s_axi_wready,
    input wire logic [1:0]            s_axi_bresp,
    input wire logic                  s_axi_bvalid,
    input wire logic                  s_axi_arvalid,
    input wire logic                  s_axi_arready,
    input wire logic                  s_axi_rvalid,
    input wire prc_pkg::prc_clk_sel_t clk_sel,
    input wire logic                  cpu_halt,
    input wire logic                  core_clk_run,
    input wire logic                  periph_clk_run,
    input wire logic                  wdt_por_req,
    input wire logic                  wdt_manual_req,
    input wire logic                  interval_req
);
    import prc_pkg::*;
    logic any_req;
    assign any_req = interval_req | wdt_por_req | wdt_manual_req;
    default clocking mcb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // ****************************************
    // assertions
    // ****************************************
    a_reset_ratio: assert property ($rose(aresetn) |-> clk_sel == 9'h002 && !cpu_halt)
        else $error("ratio codes wrong after reset");
    a_gate_only_halt: assert property (!cpu_halt |-> core_clk_run && periph_clk_run)
        else $error("clock gated outside settling");
    a_sel_frozen: assert property (cpu_halt && $past(cpu_halt) |-> $stable(clk_sel))
        else $error("ratio codes moved while settling");
    a_mult_at_resume: assert property ($changed(clk_sel.mult) |-> $fell(cpu_halt))
        else $error("multiplier applied without settling");
    a_quiet_resume: assert property ($fell(cpu_halt) |-> (!any_req)[*3])
        else $error("request raised by settling overflow");
    a_req_pulse: assert property (any_req |=> !any_req)
        else $error("request longer than one cycle");
    a_one_req: assert property ($onehot0({interval_req, wdt_por_req, wdt_manual_req}))
        else $error("more than one overflow request");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write not answered");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while answer pending");
    cover property ($rose(cpu_halt));
    cover property (interval_req);
    cover property (wdt_manual_req);
    cover property (s_axi_bvalid && s_axi_bresp == PRC_SLVERR);
endmodule : prc_clock_ratio_ctrl_monitor

bind prc_clock_ratio_ctrl prc_clock_ratio_ctrl_monitor mon (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .clk_sel, .cpu_halt, .core_clk_run,
    .periph_clk_run, .wdt_por_req, .wdt_manual_req, .interval_req);

/* File: verif/prc_periph_src.sv */
// peripheral clock tick source standing for the on-chip clocked modules
`timescale 1ns/100ps
module prc_periph_src (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic slow,
    output logic      periph_tick
);
    logic phase;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase <= 1'b0;
        end else begin
            phase <= ~phase;
        end
    end
    // keeps ticking while the core clocks are gated; slow halves the rate
    assign periph_tick = aresetn & (~slow | phase);
endmodule : prc_periph_src

/* File: verif/prc_clock_ratio_ctrl_bench.sv */
// self-checking bench for the clock ratio control block
`timescale 1ns/100ps
module prc_clock_ratio_ctrl_bench;
    import prc_pkg::*;
    localparam logic [31:0] A_FRQ = 32'hfffffe00;
    localparam logic [31:0] A_CNT = 32'hfffffe10;
    localparam logic [31:0] A_CSR = 32'hfffffe18;
    localparam logic [31:0] A_STS = 32'hfffffe20;
    localparam int          DV [8] = '{1, 4, 16, 32, 64, 256, 1024, 4096};
    logic         aclk = 1'b0, aresetn = 1'b0, slow = 1'b0;
    logic [31:0]  s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
    logic [3:0]   s_axi_wstrb = '0;
    logic [2:0]   s_axi_awprot = '0, s_axi_arprot = '0, clock_mode_pin = '0;
    logic         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, periph_tick;
    logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]   s_axi_bresp, s_axi_rresp;
    logic         cpu_halt, core_clk_run, periph_clk_run;
    logic         wdt_por_req, wdt_manual_req, interval_req;
    prc_clk_sel_t clk_sel;
    int           fail_count = 0, num_checks = 0, cycles = 0;

    always #2.5 aclk = ~aclk;

    prc_clock_ratio_ctrl uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .clock_mode_pin, .periph_tick, .clk_sel, .cpu_halt, .core_clk_run,
        .periph_clk_run, .wdt_por_req, .wdt_manual_req, .interval_req);
    prc_periph_src tick_src (.aclk, .aresetn, .slow, .periph_tick);

    // ****************************************
    // bus cycles and comparison
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [31:0] a, input logic [31:0] d,
                      input logic [3:0] s = PRC_WORD_STRB, input logic [1:0] er = PRC_OKAY);
        logic ta, tw, done;
        logic [1:0] r;
        done = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!done) begin
            @(negedge aclk);
            ta = s_axi_awvalid & s_axi_awready;
            tw = s_axi_wvalid & s_axi_wready;
            done = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (done) s_axi_bready <= 1'b0;
        end
        chk({done, r}, {1'b1, er});
    endtask : wr

    task automatic rd(input logic [31:0] a, input logic [31:0] exp,
                      input logic [1:0] er = PRC_OKAY);
        logic ta, done;
        logic [31:0] d;
        logic [1:0] r;
        done = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!done) begin
            @(negedge aclk);
            ta = s_axi_arvalid & s_axi_arready;
            done = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'b0;
            if (done) s_axi_rready <= 1'b0;
        end
        chk({done, r}, {1'b1, er});
        if (er === PRC_OKAY) chk(d, exp);
    endtask : rd

    task automatic wait_req(output int at);
        int n;
        n = 0;
        do begin
            @(negedge aclk);
            n++;
        end while (!(interval_req | wdt_por_req | wdt_manual_req) && n < 5000);
        at = cycles;
    endtask : wait_req

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        rd(A_FRQ, 32'h0102);
        rd(A_CNT, 32'h0);
        rd(A_CSR, 32'h0);
        chk(clk_sel, 9'h002);
    endtask : t_reset

    task automatic t_keys();
        wr(A_CNT, 32'h5a33);
        wr(A_CNT, 32'ha544);
        wr(A_CNT, 32'h5a44, 4'hf);
        wr(A_CSR, 32'h5a07);
        rd(A_CNT, 32'h33);
        rd(A_CSR, 32'h0);
    endtask : t_keys

    task automatic t_settle(input logic [2:0] m, input logic [15:0] f, input logic [8:0] sel);
        logic [8:0] old;
        logic g;
        int n;
        g = !(m inside {3'h0, 3'h1, 3'h2, 3'h7});
        n = 0;
        clock_mode_pin <= m;
        slow <= 1'b1;
        wr(A_CSR, 32'ha560);
        wr(A_CNT, 32'h5af0);
        old = clk_sel;
        wr(A_FRQ, {16'h0, f});
        @(negedge aclk);
        chk({cpu_halt, clk_sel}, {1'b1, old});
        chk({core_clk_run, periph_clk_run}, {g, g});
        while (cpu_halt && n < 300) begin
            @(negedge aclk);
            n++;
        end
        chk({cpu_halt, core_clk_run, periph_clk_run, clk_sel}, {3'b011, sel});
        chk(n > 24, 1);
        @(posedge aclk);
        slow <= 1'b0;
        rd(A_CSR, 32'h60);
        rd(A_CNT, 32'h0);
    endtask : t_settle

    task automatic t_reserved();
        wr(A_FRQ, 32'h3ed5);
        @(negedge aclk);
        chk({cpu_halt, clk_sel}, {1'b0, 9'h04d});
        rd(A_STS, 32'h044d);
        rd(A_FRQ, 32'h2115);
        wr(A_FRQ, 32'h0112, 4'h1);
        rd(A_FRQ, 32'h2115);
    endtask : t_reserved

    task automatic t_overflow();
        logic [7:0] v;
        int t0;
        int t1;
        for (int i = 0; i < 10; i++) begin
            v = (i < 8) ? (8'h80 | 8'(i)) : ((i == 8) ? 8'hc0 : 8'he0);
            wr(A_CNT, 32'h5aff);
            wr(A_CSR, {16'h0, 8'ha5, v});
            wait_req(t0);
            chk({interval_req, wdt_por_req, wdt_manual_req},
                {~v[6], v[6] & ~v[5], v[6] & v[5]});
            wr(A_CNT, 32'h5aff);
            wait_req(t1);
            if (v[2:0] > 3'h1) chk(t1 - t0, DV[v[2:0]]);
            rd(A_CSR, {24'h0, v | (v[6] ? 8'h10 : 8'h08)});
            wr(A_CSR, 32'ha500);
        end
    endtask : t_overflow

    task automatic t_por();
        wr(A_FRQ, 32'h0101);
        wr(A_CNT, 32'h5a5c);
        wr(A_CSR, 32'ha527);
        rd(A_CSR, 32'h27);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(A_CNT, 32'h0);
        rd(A_CSR, 32'h0);
        rd(A_FRQ, 32'h0102);
        chk(clk_sel, 9'h002);
    endtask : t_por

    task automatic t_unmapped();
        wr(32'hfffffe40, 32'h5a00, PRC_WORD_STRB, PRC_SLVERR);
        rd(32'hfffffe40, 32'h0, PRC_SLVERR);
        rd(A_FRQ, 32'h0102);
    endtask : t_unmapped

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done

    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            test_done();
        end
    end

    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_keys();
        t_settle(3'h0, 16'h0112, 9'h042);
        t_reserved();
        t_settle(3'h3, 16'h0102, 9'h002);
        t_overflow();
        t_por();
        t_unmapped();
        test_done();
    end
endmodule : prc_clock_ratio_ctrl_bench
